// File: src/can_bus_wakeup_detector.sv
// CAN bus wake-up detector with mode-transition delay timers
// Functional notes
// RL1 - Accept a bus pulse only if wider than 0.5 us and narrower than 500 us.
// RL2 - A rejected pulse clears the pulse counter and raises no wake.
// RL3 - Each accepted pulse counts up; the third raises the wake signal.
// RL4 - A gap over 500 us between accepted pulses clears the counter, no wake.
// RL5 - Wake flag stays set until CAN normal mode is entered, which clears it.
// RL6 - Bus wake detection can be disabled; then no bus wake is produced.
// RL7 - Switch delays are timed from the eighth serial clock falling edge strobe.
// RL8 - High-side switch changes no later than 22 us after the command.
// RL9 - Watchdog trigger in normal-request mode enters normal mode in 15..70 us.
// RL10 - CAN normal command puts the CAN interface in normal mode within 10 us.
// RL11 - Chip-select rising wake in stop enters normal request within 15..90 us.
// RL12 - Host waits 90 us after chip-select wake before an accepted command.
// RL13 - Host waits 20 us after the interrupt wake pulse before a command.
// RL14 - In stop mode a wake drives the interrupt output low for about 10 us.
// RL15 - A bus wake is passed to the mode controller as a wake event.
`timescale 1ns/1ps
`include "wake_defs.svh"
module can_bus_wakeup_detector
  import wake_pkg::*;
#(
  parameter logic [`CNT_W-1:0] FILT_MAX_CYC = `CNT_W'(`NS2CYC_DN(`FILT_MAX_NS)),
  parameter logic [`CNT_W-1:0] GAP_MAX_CYC = `CNT_W'(`NS2CYC_DN(`GAP_MAX_NS))
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic bus_rx_n,
  input wire logic cs_n,
  input wire logic can_wake_enable,
  input wire mode_t device_mode,
  input wire cmd_t cmd,
  output logic can_wake_flag_reg,
  output logic wake_event_reg,
  output logic can_normal_mode_reg,
  output logic battery_high_side_switch_reg,
  output logic secondary_regulator_reg,
  output logic normal_entry_reg,
  output logic normal_request_entry_reg,
  output logic int_n_reg
);
  localparam logic [`CNT_W-1:0] FILT_MIN_CYC = `CNT_W'(`NS2CYC_DN(`FILT_MIN_NS));
  localparam logic [`CNT_W-1:0] HS_CYC = `CNT_W'(`NS2CYC_DN(`HS_MAX_NS));
  localparam logic [`CNT_W-1:0] REG2_CYC = `CNT_W'(`NS2CYC_UP(`REG2_MIN_NS));
  localparam logic [`CNT_W-1:0] NR2N_CYC = `CNT_W'(`NS2CYC_UP(`NR2N_MIN_NS));
  localparam logic [`CNT_W-1:0] CAN_CYC = `CNT_W'(`NS2CYC_DN(`CAN_MAX_NS));
  localparam logic [`CNT_W-1:0] CSW_CYC = `CNT_W'(`NS2CYC_UP(`CSW_MIN_NS));
  localparam logic [`CNT_W-1:0] INT_CYC = `CNT_W'(`NS2CYC_DN(`INT_TYP_NS));
  localparam logic [1:0] LAST_PULSE = 2'(`WAKE_PULSES - 1);
  localparam logic [`CNT_W-1:0] ONE = `CNT_W'(1);
  localparam int HS_MAX_I = `NS2CYC_DN(`HS_MAX_NS);
  localparam int CAN_MAX_I = `NS2CYC_DN(`CAN_MAX_NS);
  localparam int NR_MIN_I = `NS2CYC_UP(`NR2N_MIN_NS);
  localparam int NR_MAX_I = `NS2CYC_DN(`NR2N_MAX_NS);
  localparam int CSW_MIN_I = `NS2CYC_UP(`CSW_MIN_NS);
  localparam int CSW_MAX_I = `NS2CYC_DN(`CSW_MAX_NS);

  logic rx_meta_reg, rx_sync_reg, cs_meta_reg, cs_sync_reg, cs_old_reg;
  filt_t filt_reg, filt_next;
  logic [`CNT_W-1:0] width_reg, width_next, gap_reg, gap_next;
  logic [1:0] pulse_cnt_reg, pulse_cnt_next;
  logic pulse_end, accept, reject, gap_timeout, low_power, wake_set, wake_clear;
  logic can_wake_flag_next, wake_event_next;
  logic [`CNT_W-1:0] hs_tmr_reg, hs_tmr_next, reg2_tmr_reg, reg2_tmr_next;
  logic [`CNT_W-1:0] can_tmr_reg, can_tmr_next, nr_tmr_reg, nr_tmr_next;
  logic [`CNT_W-1:0] csw_tmr_reg, csw_tmr_next, int_tmr_reg, int_tmr_next;
  logic hs_target_reg, hs_target_next, reg2_target_reg, reg2_target_next;
  logic can_normal_mode_next, hs_next, reg2_next, normal_entry_next;
  logic normal_request_entry_next, int_n_next, cs_wake;
  logic [`CNT_W-1:0] nr_age_reg, nr_age_next, cs_age_reg, cs_age_next;

  function automatic logic [`CNT_W-1:0] tick(input logic [`CNT_W-1:0] t);
    tick = (t != '0) ? t - ONE : t;
  endfunction

  // Pin synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_old_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= bus_rx_n;
      rx_sync_reg <= rx_meta_reg;
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_old_reg <= cs_sync_reg;
    end
  end

  // Pulse width filter, pulse counter and wake timeout
  always_comb
  begin
    filt_next = filt_reg;
    width_next = width_reg;
    pulse_end = 1'b0;
    case (filt_reg)
      F_RECESSIVE:
      begin
        if (!rx_sync_reg)
        begin
          filt_next = F_DOMINANT;
          width_next = ONE;
        end
      end
      F_DOMINANT:
      begin
        if (rx_sync_reg)
        begin
          filt_next = F_RECESSIVE;
          pulse_end = 1'b1;
        end
        else if (width_reg != FILT_MAX_CYC)
        begin
          width_next = width_reg + ONE;
        end
      end
      default:
        filt_next = F_RECESSIVE;
    endcase
    accept = pulse_end && (width_reg > FILT_MIN_CYC) && (width_reg < FILT_MAX_CYC); // [RL1]
    reject = (pulse_end && !accept) ||
             ((filt_reg == F_DOMINANT) && (width_reg == FILT_MAX_CYC));
    gap_timeout = (pulse_cnt_reg != 2'h0) && (gap_reg > GAP_MAX_CYC); // [RL4]
    low_power = (device_mode == M_STOP) || (device_mode == M_SLEEP);
    wake_set = 1'b0;
    pulse_cnt_next = pulse_cnt_reg;
    if (!can_wake_enable || !low_power || reject || gap_timeout) // [RL2] [RL4] [RL6]
      pulse_cnt_next = 2'h0;
    else if (accept)
    begin
      if (pulse_cnt_reg == LAST_PULSE) // [RL3]
      begin
        wake_set = 1'b1;
        pulse_cnt_next = 2'h0;
      end
      else
      begin
        pulse_cnt_next = pulse_cnt_reg + 2'h1;
      end
    end
    gap_next = (accept || pulse_cnt_next == 2'h0) ? '0 :
               ((gap_reg > GAP_MAX_CYC) ? gap_reg : gap_reg + ONE);
    wake_clear = (can_tmr_reg == ONE) && !cmd.can_leave;
    // Set wins over the clear by CAN normal entry
    can_wake_flag_next = wake_set ? 1'b1 : (wake_clear ? 1'b0 : can_wake_flag_reg); // [RL5]
    wake_event_next = wake_set; // [RL15]
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      filt_reg <= F_RECESSIVE;
      width_reg <= '0;
      gap_reg <= '0;
      pulse_cnt_reg <= 2'h0;
      can_wake_flag_reg <= 1'b0;
      wake_event_reg <= 1'b0;
    end
    else
    begin
      filt_reg <= filt_next;
      width_reg <= width_next;
      gap_reg <= gap_next;
      pulse_cnt_reg <= pulse_cnt_next;
      can_wake_flag_reg <= can_wake_flag_next;
      wake_event_reg <= wake_event_next;
    end
  end

  // Mode-transition delay timers; commands arrive on the 8th clock falling edge strobe
  always_comb
  begin
    cs_wake = cs_sync_reg && !cs_old_reg && (device_mode == M_STOP);
    hs_tmr_next = tick(hs_tmr_reg);
    reg2_tmr_next = tick(reg2_tmr_reg);
    can_tmr_next = tick(can_tmr_reg);
    nr_tmr_next = tick(nr_tmr_reg);
    csw_tmr_next = tick(csw_tmr_reg);
    int_tmr_next = tick(int_tmr_reg);
    hs_target_next = hs_target_reg;
    reg2_target_next = reg2_target_reg;
    if (cmd.hs_on || cmd.hs_off) // [RL7]
    begin
      hs_tmr_next = HS_CYC;
      hs_target_next = cmd.hs_on;
    end
    if (cmd.reg2_on || cmd.reg2_off) // [RL7]
    begin
      reg2_tmr_next = REG2_CYC;
      reg2_target_next = cmd.reg2_on;
    end
    if (cmd.can_normal)
      can_tmr_next = CAN_CYC;
    if (cmd.wd_trigger && device_mode == M_NORMAL_REQ)
      nr_tmr_next = NR2N_CYC;
    if (cs_wake)
      csw_tmr_next = CSW_CYC;
    if ((wake_set || cs_wake) && device_mode == M_STOP) // [RL14]
      int_tmr_next = INT_CYC;
    hs_next = (hs_tmr_reg == ONE) ? hs_target_reg : battery_high_side_switch_reg; // [RL8]
    reg2_next = (reg2_tmr_reg == ONE) ? reg2_target_reg : secondary_regulator_reg;
    can_normal_mode_next = cmd.can_leave ? 1'b0 :
                           ((can_tmr_reg == ONE) ? 1'b1 : can_normal_mode_reg); // [RL10]
    normal_entry_next = (nr_tmr_reg == ONE); // [RL9]
    normal_request_entry_next = (csw_tmr_reg == ONE); // [RL11]
    int_n_next = (int_tmr_next == '0);
    // Cycle age of each pending mode entry, only watched by the assertions
    nr_age_next = (cmd.wd_trigger && device_mode == M_NORMAL_REQ) ? ONE :
                  ((normal_entry_reg || nr_age_reg == '0) ? '0 : nr_age_reg + ONE);
    cs_age_next = cs_wake ? ONE :
                  ((normal_request_entry_reg || cs_age_reg == '0) ? '0 : cs_age_reg + ONE);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      hs_tmr_reg <= '0;
      reg2_tmr_reg <= '0;
      can_tmr_reg <= '0;
      nr_tmr_reg <= '0;
      csw_tmr_reg <= '0;
      int_tmr_reg <= '0;
      hs_target_reg <= 1'b0;
      reg2_target_reg <= 1'b0;
      battery_high_side_switch_reg <= 1'b0;
      secondary_regulator_reg <= 1'b0;
      can_normal_mode_reg <= 1'b0;
      normal_entry_reg <= 1'b0;
      normal_request_entry_reg <= 1'b0;
      int_n_reg <= 1'b1;
      nr_age_reg <= '0;
      cs_age_reg <= '0;
    end
    else
    begin
      hs_tmr_reg <= hs_tmr_next;
      reg2_tmr_reg <= reg2_tmr_next;
      can_tmr_reg <= can_tmr_next;
      nr_tmr_reg <= nr_tmr_next;
      csw_tmr_reg <= csw_tmr_next;
      int_tmr_reg <= int_tmr_next;
      hs_target_reg <= hs_target_next;
      reg2_target_reg <= reg2_target_next;
      battery_high_side_switch_reg <= hs_next;
      secondary_regulator_reg <= reg2_next;
      can_normal_mode_reg <= can_normal_mode_next;
      normal_entry_reg <= normal_entry_next;
      normal_request_entry_reg <= normal_request_entry_next;
      int_n_reg <= int_n_next;
      nr_age_reg <= nr_age_next;
      cs_age_reg <= cs_age_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_width_narrow: assert property (pulse_end && width_reg <= FILT_MIN_CYC |=> // [RL1]
    pulse_cnt_reg == 2'h0) else $error("narrow pulse was counted");
  a_reject_clears: assert property (reject |=> pulse_cnt_reg == 2'h0 && // [RL2]
    !wake_event_reg) else $error("rejected pulse did not clear counter");
  a_third_pulse: assert property ($rose(can_wake_flag_reg) |-> // [RL3]
    $past(accept) && $past(pulse_cnt_reg) == LAST_PULSE) else $error("wake without 3 pulses");
  a_gap_timeout: assert property (gap_timeout |=> pulse_cnt_reg == 2'h0 && // [RL4]
    !$rose(can_wake_flag_reg)) else $error("gap timeout missed");
  a_flag_holds: assert property (can_wake_flag_reg && !$rose(can_normal_mode_reg) |=> // [RL5]
    can_wake_flag_reg || $rose(can_normal_mode_reg)) else $error("wake flag dropped early");
  a_flag_clear: assert property ($rose(can_normal_mode_reg) && !$past(wake_set) |-> // [RL5]
    !can_wake_flag_reg) else $error("wake flag not cleared by CAN normal");
  a_disable_wake: assert property (wake_event_reg |-> $past(can_wake_enable)) // [RL6]
    else $error("wake raised while disabled");
  a_hs_delay: assert property (cmd.hs_on ##1 !cmd.hs_off [*1] |-> // [RL8]
    ##[1:HS_MAX_I] battery_high_side_switch_reg) else $error("high-side switch late");
  a_can_delay: assert property (cmd.can_normal && !cmd.can_leave |=> // [RL10]
    ##[0:CAN_MAX_I] can_normal_mode_reg) else $error("CAN normal entry late");
  a_nr_delay: assert property (nr_age_reg <= NR_MAX_I && // [RL9]
    (!normal_entry_reg || nr_age_reg >= NR_MIN_I)) else $error("normal entry out of window");
  a_cs_wake: assert property (cs_age_reg <= CSW_MAX_I && // [RL11]
    (!normal_request_entry_reg || cs_age_reg >= CSW_MIN_I)) else $error("cs wake out of window");
  a_int_pulse: assert property ($fell(int_n_reg) |=> !int_n_reg [*8]) // [RL14]
    else $error("interrupt pulse too short");
  a_wake_event: assert property (wake_set |=> wake_event_reg && can_wake_flag_reg) // [RL15]
    else $error("wake event not delivered");

  c_accept: cover property (accept);
  c_wake: cover property ($rose(can_wake_flag_reg));
  c_gap: cover property (gap_timeout);
  c_int: cover property ($rose(int_n_reg));
endmodule // can_bus_wakeup_detector

// File: src/wake_defs.svh
// Timing and count constants for the CAN bus wake-up detector
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH
`define CLK_MHZ 40
`define NS2CYC_UP(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define NS2CYC_DN(ns) (((ns) * `CLK_MHZ) / 1000)
`define FILT_MIN_NS 500
`define FILT_MAX_NS 500000
`define GAP_MAX_NS 500000
`define HS_MAX_NS 22000
`define REG2_MIN_NS 9000
`define NR2N_MIN_NS 15000
`define NR2N_MAX_NS 70000
`define CAN_MAX_NS 10000
`define CSW_MIN_NS 15000
`define CSW_MAX_NS 90000
`define INT_TYP_NS 10000
`define WAKE_PULSES 3
`define CNT_W 16
`endif

// File: src/wake_pkg.sv
// Types shared by the CAN bus wake-up detector
package wake_pkg;
  typedef enum logic [2:0] {
    M_NORMAL_REQ = 3'h0,
    M_NORMAL = 3'h1,
    M_STANDBY = 3'h2,
    M_STOP = 3'h3,
    M_SLEEP = 3'h4
  } mode_t;
  typedef enum logic {
    F_RECESSIVE = 1'b0,
    F_DOMINANT = 1'b1
  } filt_t;
  typedef struct packed {
    logic hs_on;
    logic hs_off;
    logic reg2_on;
    logic reg2_off;
    logic can_normal;
    logic can_leave;
    logic wd_trigger;
  } cmd_t;
endpackage

// File: bench/bus_node_model.sv
// Far-side model: CAN node seen through the wake receiver, and host chip-select
`timescale 1ns/1ps
module bus_node_model
(
  input wire logic ref_clk,
  output logic bus_rx_n,
  output logic cs_n
);
  initial
  begin
    bus_rx_n = 1'b1;
    cs_n = 1'b1;
  end

  // Dominant for low_cyc cycles, then recessive for gap_cyc cycles
  task automatic pulse(input int low_cyc, input int gap_cyc);
    @(posedge ref_clk);
    bus_rx_n <= 1'b0;
    repeat (low_cyc) @(posedge ref_clk);
    bus_rx_n <= 1'b1;
    repeat (gap_cyc) @(posedge ref_clk);
  endtask

  // Host selects the device briefly; the rising edge is the wake
  task automatic cs_wake();
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
  endtask
endmodule // bus_node_model

// File: bench/can_bus_wakeup_detector_tb.sv
// Self-checking bench for the CAN bus wake-up detector
`timescale 1ns/1ps
module can_bus_wakeup_detector_tb;
  import wake_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_rx_n;
  logic cs_n;
  logic can_wake_enable = 1'b1;
  mode_t device_mode = M_NORMAL;
  cmd_t cmd = '0;
  logic can_wake_flag_reg;
  logic wake_event_reg;
  logic can_normal_mode_reg;
  logic battery_high_side_switch_reg;
  logic secondary_regulator_reg;
  logic normal_entry_reg;
  logic normal_request_entry_reg;
  logic int_n_reg;
  int bad_count = 0;
  int samples_checked = 0;
  int wakes = 0;

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (wake_event_reg === 1'b1)
      wakes <= wakes + 1;

  bus_node_model node (.ref_clk(ref_clk), .bus_rx_n(bus_rx_n), .cs_n(cs_n));

  can_bus_wakeup_detector #(.FILT_MAX_CYC(16'h00C8), .GAP_MAX_CYC(16'h00C8)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus_rx_n(bus_rx_n), .cs_n(cs_n),
    .can_wake_enable(can_wake_enable), .device_mode(device_mode), .cmd(cmd),
    .can_wake_flag_reg(can_wake_flag_reg), .wake_event_reg(wake_event_reg),
    .can_normal_mode_reg(can_normal_mode_reg),
    .battery_high_side_switch_reg(battery_high_side_switch_reg),
    .secondary_regulator_reg(secondary_regulator_reg),
    .normal_entry_reg(normal_entry_reg),
    .normal_request_entry_reg(normal_request_entry_reg), .int_n_reg(int_n_reg));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return battery_high_side_switch_reg;
      1: return secondary_regulator_reg;
      2: return normal_entry_reg;
      3: return normal_request_entry_reg;
      4: return can_normal_mode_reg;
      default: return int_n_reg;
    endcase
  endfunction

  // Counts edges until the chosen output takes the value, bounded by lim
  task automatic wait_sig(input int sel, input logic val, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (pick(sel) !== val && n < lim);
  endtask

  task automatic set_mode(input mode_t m, input logic en);
    @(posedge ref_clk);
    device_mode <= m;
    can_wake_enable <= en;
  endtask

  task automatic send_cmd(input logic [6:0] c);
    @(posedge ref_clk);
    cmd <= c;
    @(posedge ref_clk);
    cmd <= '0;
  endtask

  task automatic burst(input mode_t m, input logic en, input int w[8], input int g[8],
                       input int k);
    set_mode(m, en);
    for (int i = 0; i < k; i++)
      node.pulse(w[i], g[i]);
  endtask

  task automatic no_wake(input int w[8], input int g[8], input int k, input logic en);
    int w0;
    w0 = wakes;
    burst(M_SLEEP, en, w, g, k);
    repeat (10) @(posedge ref_clk);
    check("wake count", wakes - w0, 0);
    check("wake flag", can_wake_flag_reg, 1'b0);
    set_mode(M_NORMAL, 1'b1);
  endtask

  task automatic clear_flag();
    int n;
    send_cmd(7'h04);
    wait_sig(4, 1'b1, 500, n);
    check("can normal delay ok", n <= 400, 1);
    check("flag cleared", can_wake_flag_reg, 1'b0);
    send_cmd(7'h02);
  endtask

  task automatic wake_sleep();
    int w0;
    w0 = wakes;
    burst(M_SLEEP, 1'b1, '{199, 21, 40, 0, 0, 0, 0, 0}, '{60, 60, 10, 0, 0, 0, 0, 0}, 3);
    check("one wake event", wakes - w0, 1);
    check("flag set", can_wake_flag_reg, 1'b1);
    check("no int in sleep", int_n_reg, 1'b1);
    repeat (300) @(posedge ref_clk);
    check("flag held", can_wake_flag_reg, 1'b1);
    clear_flag();
    set_mode(M_NORMAL, 1'b1);
  endtask

  task automatic wake_stop();
    int n;
    burst(M_STOP, 1'b1, '{40, 40, 40, 0, 0, 0, 0, 0}, '{60, 60, 0, 0, 0, 0, 0, 0}, 3);
    wait_sig(5, 1'b0, 10, n);
    check("int low", int_n_reg, 1'b0);
    wait_sig(5, 1'b1, 600, n);
    check("int width ok", n >= 280 && n <= 520, 1);
    repeat (800) @(posedge ref_clk);
    clear_flag();
    set_mode(M_NORMAL, 1'b1);
  endtask

  task automatic cmd_delay(input logic [6:0] c, input int sel, input logic v, input int lo,
                           input int hi);
    int n;
    send_cmd(c);
    wait_sig(sel, v, hi + 10, n);
    check("delay in window", n >= lo && n <= hi, 1);
    check("output level", pick(sel), v);
  endtask

  task automatic cs_stop();
    int n;
    set_mode(M_STOP, 1'b1);
    node.cs_wake();
    wait_sig(3, 1'b1, 4000, n);
    check("cs wake delay ok", n >= 600 && n <= 3600, 1);
    repeat (3600) @(posedge ref_clk);
    set_mode(M_NORMAL, 1'b1);
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("int idle", int_n_reg, 1'b1);
    no_wake('{40, 40, 10, 40, 40, 210, 40, 40},
            '{60, 60, 60, 60, 60, 60, 60, 60}, 8, 1'b1);
    no_wake('{40, 40, 40, 40, 0, 0, 0, 0}, '{60, 260, 60, 60, 0, 0, 0, 0}, 4, 1'b1);
    no_wake('{40, 40, 40, 0, 0, 0, 0, 0}, '{60, 60, 60, 0, 0, 0, 0, 0}, 3, 1'b0);
    wake_sleep();
    wake_stop();
    cs_stop();
    cmd_delay(7'h40, 0, 1'b1, 1, 880);
    cmd_delay(7'h20, 0, 1'b0, 1, 880);
    cmd_delay(7'h10, 1, 1'b1, 360, 880);
    cmd_delay(7'h08, 1, 1'b0, 360, 880);
    set_mode(M_NORMAL_REQ, 1'b1);
    cmd_delay(7'h01, 2, 1'b1, 600, 2800);
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end
endmodule // can_bus_wakeup_detector_tb
